/* File: inc/sps_cfg.svh */
/*
 Register offsets, field positions and reset values of the stepper pattern shifter.
 Assumes a 32-bit AXI4-Lite slave with byte addresses and one register per word.
*/
`ifndef SPS_CFG_SVH
`define SPS_CFG_SVH

`define SPS_ADDR_W        8
`define SPS_OFS_PCTRL     8'h00
`define SPS_OFS_FFCTRL    8'h04
`define SPS_OFS_TRGCTRL   8'h08
`define SPS_OFS_STATUS    8'h0C
`define SPS_OFS_PZERO     8'h4C

`define SPS_PCTRL_MODE_LO 0
`define SPS_PCTRL_MODE_HI 1
`define SPS_PCTRL_REV     2
`define SPS_MODE_ONE_TWO  2'h3

`define SPS_FF_SRC        0
`define SPS_FF_INV_EN     1

`define SPS_TRG_T4_A      0
`define SPS_TRG_T4_B      1
`define SPS_TRG_T5        2
`define SPS_TRG_SRC_LO    4
`define SPS_TRG_SRC_HI    5

`define SPS_ST_LATCH_LO   0
`define SPS_ST_LATCH_HI   3
`define SPS_ST_TMODE_LO   4
`define SPS_ST_TMODE_HI   5
`define SPS_ST_CNT_LO     8
`define SPS_ST_CNT_HI     15

`define SPS_PZ_LATCH_LO   4
`define SPS_PZ_LATCH_HI   7
`define SPS_PZ_ALT_LO     0
`define SPS_PZ_ALT_HI     3

`define SPS_RST_NIBBLE    4'h0
`define SPS_RST_BYTE      8'h00
`define SPS_RESP_OKAY     2'h0
`define SPS_RESP_SLVERR   2'h2

`endif

/* File: inc/sps_pkg.sv */
/*
 Types of the stepper pattern shifter.
 Assumes sps_cfg.svh is on the include path.
*/
package sps_pkg;

   typedef enum logic [1:0] {
      SPS_TM_8BIT,
      SPS_TM_16BIT,
      SPS_TM_PPG,
      SPS_TM_PWM
   } sps_tmode_e;

   typedef enum logic [1:0] {
      SPS_SRC_T8,
      SPS_SRC_T4,
      SPS_SRC_T5,
      SPS_SRC_NONE
   } sps_src_e;

   typedef struct packed {
      logic eq_cmp0;
      logic eq_cmp1;
      logic eq_cmp16;
      logic t4_eq_second;
      logic t5_eq_second;
   } sps_tmr_ev_s;

   typedef struct packed {
      logic toggle_src;
      logic invert_en;
      logic t4_en_a;
      logic t4_en_b;
      logic t5_en;
   } sps_trg_cfg_s;

endpackage

/* File: design/sps_trig_sel.sv */
/*
 Picks the pattern shift trigger from the timer match events and yields one
 pulse per rising edge of it. Assumes match events come from logic on aclk.
*/
module sps_trig_sel (
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   input  wire sps_pkg::sps_tmode_e  timer_mode,
   input  wire sps_pkg::sps_src_e    src,
   input  wire sps_pkg::sps_trg_cfg_s cfg,
   input  wire sps_pkg::sps_tmr_ev_s ev,
   output logic                      step
);

   logic trig;
   logic t8_trig;
   logic trig_ff;

   // Same selection as the flip-flop toggle trigger
   always_comb begin
      case (timer_mode)
         sps_pkg::SPS_TM_8BIT:  t8_trig = cfg.toggle_src ? ev.eq_cmp1 : ev.eq_cmp0;
         sps_pkg::SPS_TM_16BIT: t8_trig = ev.eq_cmp16;
         sps_pkg::SPS_TM_PPG:   t8_trig = ev.eq_cmp1;
         sps_pkg::SPS_TM_PWM:   t8_trig = 1'b0;
         default:               t8_trig = 1'b0;
      endcase
   end

   always_comb begin
      case (src)
         sps_pkg::SPS_SRC_T8: trig = t8_trig & cfg.invert_en;
         sps_pkg::SPS_SRC_T4: trig = (cfg.t4_en_a | cfg.t4_en_b) & ev.t4_eq_second;
         sps_pkg::SPS_SRC_T5: trig = cfg.t5_en & ev.t5_eq_second;
         default:             trig = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         trig_ff <= 1'b0;
      end else begin
         trig_ff <= trig;
      end
   end

   // Rising edge only
   assign step = trig & ~trig_ff;

endmodule

/* File: design/sps_ring.sv */
/*
 Output latch and shift alternate register of channel zero, rotated as one
 interleaved ring or as the latch alone. Assumes one step pulse per trigger edge.
*/
`include "sps_cfg.svh"
module sps_ring (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic       load,
   input  wire logic [7:0] load_data,
   input  wire logic       step,
   input  wire logic       one_two,
   input  wire logic       reverse,
   output logic      [3:0] latch_ff,
   output logic      [3:0] alt_ff
);

   logic [7:0] ring;
   logic [7:0] nxt_ring;
   logic [3:0] nxt_latch;

   // Ring order: latch3 alt3 latch2 alt2 latch1 alt1 latch0 alt0
   for (genvar i = 0; i < 4; i++) begin : g_ilv
      assign ring[2*i+1] = latch_ff[i];
      assign ring[2*i]   = alt_ff[i];
   end

   always_comb begin
      if (reverse) begin
         nxt_ring  = {ring[0], ring[7:1]};
         nxt_latch = {latch_ff[0], latch_ff[3:1]};
      end else begin
         nxt_ring  = {ring[6:0], ring[7]};
         nxt_latch = {latch_ff[2:0], latch_ff[3]};
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_ff <= `SPS_RST_NIBBLE;
         alt_ff   <= `SPS_RST_NIBBLE;
      end else if (load) begin
         latch_ff <= load_data[`SPS_PZ_LATCH_HI:`SPS_PZ_LATCH_LO];
         alt_ff   <= load_data[`SPS_PZ_ALT_HI:`SPS_PZ_ALT_LO];
      end else if (step && one_two) begin
         latch_ff <= {nxt_ring[7], nxt_ring[5], nxt_ring[3], nxt_ring[1]};
         alt_ff   <= {nxt_ring[6], nxt_ring[4], nxt_ring[2], nxt_ring[0]};
      end else if (step) begin
         latch_ff <= nxt_latch;
      end
      // No step: hold
   end

endmodule

/* File: design/sps_pattern_shifter.sv */
/*
 Channel zero stepping-motor pattern shifter with an AXI4-Lite register slave.
 Assumes timer match events and timer mode come from logic on aclk, and that
 a motor driver sits on pattern_pins.
*/
// The AXI4-Lite interface to the registers and the register offsets were decided locally.
`include "sps_cfg.svh"
module sps_pattern_shifter (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [`SPS_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]            s_axi_awprot,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [`SPS_ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]            s_axi_arprot,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire sps_pkg::sps_tmode_e   timer_mode,
   input  wire sps_pkg::sps_tmr_ev_s  timer_ev,
   output logic [3:0]                 pattern_pins
);

   // Write channel state
   logic                   aw_have_ff;
   logic                   w_have_ff;
   logic [`SPS_ADDR_W-1:0] awaddr_ff;
   logic [31:0]            wdata_ff;
   logic [3:0]             wstrb_ff;
   logic                   bvalid_ff;
   logic [1:0]             bresp_ff;

   // Read channel state
   logic                   rvalid_ff;
   logic [31:0]            rdata_ff;
   logic [1:0]             rresp_ff;

   // Control registers
   logic [1:0]             exc_mode_ff;
   logic                   reverse_dir_ch0_ff;
   logic                   toggle_src_ff;
   logic                   invert_en_ff;
   logic                   t4_trigger_enable_a_ff;
   logic                   t4_trigger_enable_b_ff;
   logic                   t5_trigger_enable_ff;
   logic [1:0]             trg_src_ff;
   logic [7:0]             step_cnt_ff;

   // Internal nets
   logic                   aw_take;
   logic                   w_take;
   logic                   aw_ok;
   logic                   w_ok;
   logic                   wr_fire;
   logic [`SPS_ADDR_W-1:0] wr_addr;
   logic [31:0]            wr_data;
   logic [3:0]             wr_strb;
   logic                   wr_mapped;
   logic                   rd_take;
   logic                   rd_mapped;
   logic [31:0]            rd_word;
   logic                   pz_load;
   logic                   pctrl_we;
   logic                   ffctrl_we;
   logic                   trgctl_we;
   logic                   cnt_clr;
   logic                   step;
   logic                   one_two;
   logic [3:0]             latch;
   logic [3:0]             alt;
   sps_pkg::sps_trg_cfg_s  trg_cfg;
   sps_pkg::sps_src_e      trg_src;

   // Address and data may come in either order
   assign s_axi_awready = ~aw_have_ff & ~bvalid_ff;
   assign s_axi_wready  = ~w_have_ff & ~bvalid_ff;
   assign aw_take       = s_axi_awvalid & s_axi_awready;
   assign w_take        = s_axi_wvalid & s_axi_wready;
   assign aw_ok         = aw_have_ff | aw_take;
   assign w_ok          = w_have_ff | w_take;
   assign wr_fire       = aw_ok & w_ok & ~bvalid_ff;
   assign wr_addr       = aw_have_ff ? awaddr_ff : s_axi_awaddr;
   assign wr_data       = w_have_ff ? wdata_ff : s_axi_wdata;
   assign wr_strb       = w_have_ff ? wstrb_ff : s_axi_wstrb;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_ff <= 1'b0;
      end else if (wr_fire) begin
         aw_have_ff <= 1'b0;
      end else if (aw_take) begin
         aw_have_ff <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awaddr_ff <= `SPS_RST_BYTE;
      end else if (aw_take) begin
         awaddr_ff <= s_axi_awaddr;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_have_ff <= 1'b0;
      end else if (wr_fire) begin
         w_have_ff <= 1'b0;
      end else if (w_take) begin
         w_have_ff <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wdata_ff <= 32'h00000000;
         wstrb_ff <= 4'h0;
      end else if (w_take) begin
         wdata_ff <= s_axi_wdata;
         wstrb_ff <= s_axi_wstrb;
      end
   end

   always_comb begin
      case (wr_addr)
         `SPS_OFS_PCTRL,
         `SPS_OFS_FFCTRL,
         `SPS_OFS_TRGCTRL,
         `SPS_OFS_STATUS,
         `SPS_OFS_PZERO: wr_mapped = 1'b1;
         default:        wr_mapped = 1'b0;
      endcase
   end

   // Write response stands until bready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_ff <= 1'b0;
      end else if (wr_fire) begin
         bvalid_ff <= 1'b1;
      end else if (s_axi_bready) begin
         bvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bresp_ff <= `SPS_RESP_OKAY;
      end else if (wr_fire) begin
         bresp_ff <= wr_mapped ? `SPS_RESP_OKAY : `SPS_RESP_SLVERR;
      end
   end

   assign s_axi_bvalid = bvalid_ff;
   assign s_axi_bresp  = bresp_ff;

   // Pattern control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         exc_mode_ff        <= 2'h0;
         reverse_dir_ch0_ff <= 1'b0;
      end else if (pctrl_we) begin
         exc_mode_ff        <= wr_data[`SPS_PCTRL_MODE_HI:`SPS_PCTRL_MODE_LO];
         reverse_dir_ch0_ff <= wr_data[`SPS_PCTRL_REV];
      end
   end

   // Flip-flop control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         toggle_src_ff <= 1'b0;
         invert_en_ff  <= 1'b0;
      end else if (ffctrl_we) begin
         toggle_src_ff <= wr_data[`SPS_FF_SRC];
         invert_en_ff  <= wr_data[`SPS_FF_INV_EN];
      end
   end

   // Trigger control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         t4_trigger_enable_a_ff <= 1'b0;
         t4_trigger_enable_b_ff <= 1'b0;
         t5_trigger_enable_ff   <= 1'b0;
         trg_src_ff             <= 2'h0;
      end else if (trgctl_we) begin
         t4_trigger_enable_a_ff <= wr_data[`SPS_TRG_T4_A];
         t4_trigger_enable_b_ff <= wr_data[`SPS_TRG_T4_B];
         t5_trigger_enable_ff   <= wr_data[`SPS_TRG_T5];
         trg_src_ff             <= wr_data[`SPS_TRG_SRC_HI:`SPS_TRG_SRC_LO];
      end
   end

   // One write strobe per register; pattern write loads latch and alternate
   always_comb begin
      pctrl_we  = 1'b0;
      ffctrl_we = 1'b0;
      trgctl_we = 1'b0;
      cnt_clr   = 1'b0;
      pz_load   = 1'b0;
      if (wr_fire) begin
         case (wr_addr)
            `SPS_OFS_PCTRL: begin
               pctrl_we = wr_strb[0];
            end
            `SPS_OFS_FFCTRL: begin
               ffctrl_we = wr_strb[0];
            end
            `SPS_OFS_TRGCTRL: begin
               trgctl_we = wr_strb[0];
            end
            `SPS_OFS_STATUS: begin
               cnt_clr = wr_strb[1];
            end
            `SPS_OFS_PZERO: begin
               pz_load = wr_strb[0];
            end
            default: begin
               pz_load = 1'b0;
            end
         endcase
      end
   end

   // Count of applied shifts, shown in status
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         step_cnt_ff <= `SPS_RST_BYTE;
      end else if (cnt_clr) begin
         step_cnt_ff <= `SPS_RST_BYTE;
      end else if (step && !pz_load) begin
         step_cnt_ff <= step_cnt_ff + 8'h01;
      end
   end

   // Trigger selection
   assign trg_cfg.toggle_src = toggle_src_ff;
   assign trg_cfg.invert_en  = invert_en_ff;
   assign trg_cfg.t4_en_a    = t4_trigger_enable_a_ff;
   assign trg_cfg.t4_en_b    = t4_trigger_enable_b_ff;
   assign trg_cfg.t5_en      = t5_trigger_enable_ff;
   assign trg_src            = sps_pkg::sps_src_e'(trg_src_ff);

   sps_trig_sel u_trig (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .timer_mode (timer_mode),
      .src        (trg_src),
      .cfg        (trg_cfg),
      .ev         (timer_ev),
      .step       (step)
   );

   // Ring shifter
   assign one_two = (exc_mode_ff == `SPS_MODE_ONE_TWO);

   sps_ring u_ring (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .load      (pz_load),
      .load_data (wr_data[7:0]),
      .step      (step),
      .one_two   (one_two),
      .reverse   (reverse_dir_ch0_ff),
      .latch_ff  (latch),
      .alt_ff    (alt)
   );

   // Pins follow the latch directly
   assign pattern_pins = latch;

   // Read decode
   always_comb begin
      rd_word   = 32'h00000000;
      rd_mapped = 1'b1;
      case (s_axi_araddr)
         `SPS_OFS_PCTRL: begin
            rd_word[`SPS_PCTRL_MODE_HI:`SPS_PCTRL_MODE_LO] = exc_mode_ff;
            rd_word[`SPS_PCTRL_REV]                        = reverse_dir_ch0_ff;
         end
         `SPS_OFS_FFCTRL: begin
            rd_word[`SPS_FF_SRC]    = toggle_src_ff;
            rd_word[`SPS_FF_INV_EN] = invert_en_ff;
         end
         `SPS_OFS_TRGCTRL: begin
            rd_word[`SPS_TRG_T4_A]                     = t4_trigger_enable_a_ff;
            rd_word[`SPS_TRG_T4_B]                     = t4_trigger_enable_b_ff;
            rd_word[`SPS_TRG_T5]                       = t5_trigger_enable_ff;
            rd_word[`SPS_TRG_SRC_HI:`SPS_TRG_SRC_LO]   = trg_src_ff;
         end
         `SPS_OFS_STATUS: begin
            rd_word[`SPS_ST_LATCH_HI:`SPS_ST_LATCH_LO] = latch;
            rd_word[`SPS_ST_TMODE_HI:`SPS_ST_TMODE_LO] = timer_mode;
            rd_word[`SPS_ST_CNT_HI:`SPS_ST_CNT_LO]     = step_cnt_ff;
         end
         `SPS_OFS_PZERO: begin
            // Latch nibble is write-only and reads zero
            rd_word[`SPS_PZ_ALT_HI:`SPS_PZ_ALT_LO] = alt;
         end
         default: begin
            rd_mapped = 1'b0;
         end
      endcase
   end

   // Read channel
   assign s_axi_arready = ~rvalid_ff;
   assign rd_take       = s_axi_arvalid & s_axi_arready;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_ff <= 1'b0;
      end else if (rd_take) begin
         rvalid_ff <= 1'b1;
      end else if (s_axi_rready) begin
         rvalid_ff <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rdata_ff <= 32'h00000000;
         rresp_ff <= `SPS_RESP_OKAY;
      end else if (rd_take) begin
         rdata_ff <= rd_word;
         rresp_ff <= rd_mapped ? `SPS_RESP_OKAY : `SPS_RESP_SLVERR;
      end
   end

   assign s_axi_rvalid = rvalid_ff;
   assign s_axi_rdata  = rdata_ff;
   assign s_axi_rresp  = rresp_ff;

endmodule

/* File: tb/sps_chk.sv */
/*
 Port checker of the stepper pattern shifter: bus handshakes and pin hold.
 Assumes it is bound to sps_pattern_shifter, one clock, synchronous reset.
*/
`include "sps_cfg.svh"
module sps_chk (
   input wire logic                   aclk,
   input wire logic                   aresetn,
   input wire logic                   s_axi_awvalid,
   input wire logic                   s_axi_awready,
   input wire logic                   s_axi_wvalid,
   input wire logic                   s_axi_wready,
   input wire logic [1:0]             s_axi_bresp,
   input wire logic                   s_axi_bvalid,
   input wire logic                   s_axi_bready,
   input wire logic [`SPS_ADDR_W-1:0] s_axi_araddr,
   input wire logic                   s_axi_arvalid,
   input wire logic                   s_axi_arready,
   input wire logic [31:0]            s_axi_rdata,
   input wire logic [1:0]             s_axi_rresp,
   input wire logic                   s_axi_rvalid,
   input wire logic                   s_axi_rready,
   input wire sps_pkg::sps_tmode_e    timer_mode,
   input wire sps_pkg::sps_tmr_ev_s   timer_ev,
   input wire logic [3:0]             pattern_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] ev_v;
   assign ev_v = timer_ev;
   default clocking @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   pin_hold_a: assert property (
      (ev_v & ~$past(ev_v)) == 5'h00 && !s_axi_wvalid |=> $stable(pattern_pins))
      else $error("pins moved without trigger or write");
   pwm_quiet_a: assert property (
      timer_mode == sps_pkg::SPS_TM_PWM && ev_v[1:0] == 2'h0 && !s_axi_wvalid
      |=> $stable(pattern_pins)) else $error("pins moved in pwm mode");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read response dropped");
   ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
   bad_addr_a: assert property (s_axi_arvalid && s_axi_arready && !(s_axi_araddr inside
      {`SPS_OFS_PCTRL, `SPS_OFS_FFCTRL, `SPS_OFS_TRGCTRL, `SPS_OFS_STATUS, `SPS_OFS_PZERO})
      |=> s_axi_rresp == `SPS_RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   shift_c: cover property ((ev_v & ~$past(ev_v)) != 5'h00 ##1 !$stable(pattern_pins));
   pwm_c: cover property (timer_mode == sps_pkg::SPS_TM_PWM && ev_v != 5'h00);
   rwait_c: cover property (s_axi_rvalid && !s_axi_rready);
endmodule
bind sps_pattern_shifter sps_chk u_chk (.*);

/* File: tb/sps_tmr_model.sv */
/*
 Timer side of the shifter: raises match event levels on request and
 holds them for a chosen number of extra cycles.
 Assumes requests change just after a rising edge of aclk.
*/
module sps_tmr_model (
   input  wire logic            aclk,
   input  wire logic            aresetn,
   input  wire logic            fire,
   input  wire logic [4:0]      fire_ev,
   input  wire logic [1:0]      hold,
   output sps_pkg::sps_tmr_ev_s timer_ev
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] ev_ff;
   logic [1:0] left_ff;
   assign timer_ev = ev_ff;
   // A match level lasts while the counter equals the compare value
   always_ff @(posedge aclk) begin
      if (!aresetn || (!fire && left_ff == 2'h0)) begin
         ev_ff <= 5'h00;
         left_ff <= 2'h0;
      end else if (fire) begin
         ev_ff <= fire_ev;
         left_ff <= hold;
      end else begin
         left_ff <= left_ff - 2'h1;
      end
   end
endmodule

/* File: tb/stepper_pattern_shifter_tb.sv */
/*
 Bench of the stepper pattern shifter: registers over AXI4-Lite and ring
 rotation on timer events, checked against an 8-bit ring model.
 Assumes the timer model on timer_ev and the checker bound to the design.
*/
`include "sps_cfg.svh"
module stepper_pattern_shifter_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                aclk = 1'b0, aresetn = 1'b0, fire = 1'b0, rev = 1'b0;
   logic                awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic                arvalid = 1'b0, rready = 1'b0;
   logic                awready, wready, bvalid, arready, rvalid;
   logic [7:0]          awaddr = 8'h00, araddr = 8'h00, ring, cnt;
   logic [31:0]         wdata = 32'h0, rd, rdata;
   logic [3:0]          wstrb = 4'hF, pattern_pins;
   logic [1:0]          bresp, rresp, rsp, hold = 2'h0;
   logic [4:0]          fire_ev = 5'h00;
   logic [2:0]          sh_tab [3] = '{3'b001, 3'b010, 3'b000};
   sps_pkg::sps_tmode_e timer_mode = sps_pkg::SPS_TM_8BIT;
   sps_pkg::sps_tmode_e md [3] = '{sps_pkg::SPS_TM_16BIT, sps_pkg::SPS_TM_PPG,
                                   sps_pkg::SPS_TM_PWM};
   sps_pkg::sps_tmr_ev_s timer_ev;
   int                  errors = 0, comparisons = 0, i, j;
   always #2 aclk = ~aclk;
   sps_pattern_shifter dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .timer_mode(timer_mode),
      .timer_ev(timer_ev), .pattern_pins(pattern_pins));
   sps_tmr_model tmr (.aclk(aclk), .aresetn(aresetn), .fire(fire), .fire_ev(fire_ev),
      .hold(hold), .timer_ev(timer_ev));
   task automatic conclude;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // One bus transfer; ready and answer are looked at between edges
   task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d);
      logic aw_t, w_t, ar_t, v, t;
      int n;
      @(posedge aclk);
      if (we) begin
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
      end else begin
         araddr <= a;
         arvalid <= 1'b1;
      end
      for (n = 0; n < 40; n++) begin
         @(negedge aclk);
         aw_t = awvalid && awready;
         w_t = wvalid && wready;
         ar_t = arvalid && arready;
         v = we ? bvalid : rvalid;
         t = v && (we ? bready : rready);
         rsp = we ? bresp : rresp;
         rd = rdata;
         @(posedge aclk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         if (ar_t) arvalid <= 1'b0;
         if (t) begin
            bready <= 1'b0;
            rready <= 1'b0;
            return;
         end
         if (v) begin
            bready <= we;
            rready <= !we;
         end
      end
      errors++;
      conclude();
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      xfer(1'b0, a, 32'h0);
      chk("rdata", d, rd);
      chk("rresp", {30'h0, r}, {30'h0, rsp});
   endtask
   task automatic fire_chk(input logic [4:0] e, input logic sh, input logic [1:0] h);
      @(posedge aclk);
      fire_ev <= e;
      hold <= h;
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      repeat (6) @(posedge aclk);
      if (sh) begin
         ring = rev ? {ring[0], ring[7:1]} : {ring[6:0], ring[7]};
         cnt++;
      end
      chk("pins", {28'h0, ring[7], ring[5], ring[3], ring[1]}, {28'h0, pattern_pins});
   endtask
   task automatic load(input logic [7:0] d);
      xfer(1'b1, `SPS_OFS_PZERO, {24'h0, d});
      ring = {d[7], d[3], d[6], d[2], d[5], d[1], d[4], d[0]};
   endtask
   initial begin
      cnt = 8'h00;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      foreach (md[k]) rchk(8'h04 * k, 32'h0, `SPS_RESP_OKAY);
      rchk(`SPS_OFS_STATUS, 32'h0, `SPS_RESP_OKAY);
      rchk(`SPS_OFS_PZERO, 32'h0, `SPS_RESP_OKAY);
      rchk(8'h10, 32'h0, `SPS_RESP_SLVERR);
      xfer(1'b1, 8'h10, 32'h5);
      chk("bresp", {30'h0, `SPS_RESP_SLVERR}, {30'h0, rsp});
      $display("test reset and map done");
      load(8'hC8);
      rchk(`SPS_OFS_PZERO, 32'h8, `SPS_RESP_OKAY);
      xfer(1'b1, `SPS_OFS_PCTRL, 32'h3);
      xfer(1'b1, `SPS_OFS_FFCTRL, 32'h2);
      xfer(1'b1, `SPS_OFS_TRGCTRL, 32'h0);
      wstrb <= 4'h0;
      xfer(1'b1, `SPS_OFS_PCTRL, 32'h0);
      wstrb <= 4'hF;
      rchk(`SPS_OFS_PCTRL, 32'h3, `SPS_RESP_OKAY);
      fire_chk(5'h00, 1'b0, 2'h0);
      for (i = 0; i < 8; i++) fire_chk(5'h10, 1'b1, 2'h0);
      fire_chk(5'h08, 1'b0, 2'h0);
      fire_chk(5'h10, 1'b1, 2'h3);
      rchk(`SPS_OFS_STATUS, {16'h0, cnt, 4'h0, ring[7], ring[5], ring[3], ring[1]},
         `SPS_RESP_OKAY);
      xfer(1'b1, `SPS_OFS_STATUS, 32'h0);
      cnt = 8'h00;
      xfer(1'b1, `SPS_OFS_FFCTRL, 32'h3);
      fire_chk(5'h10, 1'b0, 2'h0);
      xfer(1'b1, `SPS_OFS_PCTRL, 32'h7);
      rev = 1'b1;
      for (i = 0; i < 8; i++) fire_chk(5'h08, 1'b1, 2'h0);
      $display("test 8-bit rotation done");
      for (i = 0; i < 3; i++) begin
         timer_mode <= md[i];
         for (j = 0; j < 3; j++) begin
            fire_chk(5'h10 >> j, sh_tab[i][2-j], 2'h0);
         end
      end
      timer_mode <= sps_pkg::SPS_TM_8BIT;
      xfer(1'b1, `SPS_OFS_FFCTRL, 32'h1);
      fire_chk(5'h08, 1'b0, 2'h0);
      $display("test timer modes done");
      xfer(1'b1, `SPS_OFS_TRGCTRL, 32'h11);
      fire_chk(5'h02, 1'b1, 2'h0);
      fire_chk(5'h01, 1'b0, 2'h0);
      xfer(1'b1, `SPS_OFS_TRGCTRL, 32'h12);
      fire_chk(5'h02, 1'b1, 2'h0);
      xfer(1'b1, `SPS_OFS_TRGCTRL, 32'h10);
      fire_chk(5'h02, 1'b0, 2'h0);
      xfer(1'b1, `SPS_OFS_TRGCTRL, 32'h24);
      fire_chk(5'h01, 1'b1, 2'h0);
      fire_chk(5'h02, 1'b0, 2'h0);
      load(8'h37);
      xfer(1'b1, `SPS_OFS_PCTRL, 32'h3);
      rev = 1'b0;
      for (i = 0; i < 3; i++) fire_chk(5'h01, 1'b1, 2'h0);
      // Mode other than 1-2 step rotates the latch nibble alone
      xfer(1'b1, `SPS_OFS_PCTRL, 32'h1);
      ring = {ring[5], ring[6], ring[3], ring[4], ring[1], ring[2], ring[7], ring[0]};
      cnt++;
      fire_chk(5'h01, 1'b0, 2'h0);
      rchk(`SPS_OFS_STATUS, {16'h0, cnt, 4'h0, ring[7], ring[5], ring[3], ring[1]},
         `SPS_RESP_OKAY);
      $display("test 16-bit triggers done");
      conclude();
   end
endmodule
